// File: sim/rles_link_model.sv
`timescale 1ns/10ps
module rles_link_model #(
    parameter LANES = 20
) (
    input  wire                 clock,
    // pcs lanes
    output logic [LANES-1:0]    blk_valid,
    output logic [LANES*66-1:0] blk_data,
    output logic [LANES-1:0]    blk_marker,
    // columns
    output logic                col_valid,
    output logic                col_is_lf,
    output logic                col_is_seq
);
    initial begin
        blk_valid = '0;
        blk_marker = '0;
        blk_data = '0;
        col_valid = 1'b0;
        col_is_lf = 1'b0;
        col_is_seq = 1'b0;
    end
    // released lanes flip their data so stale blocks never look held
    task automatic idle_lanes();
        blk_valid <= '0;
        blk_marker <= '0;
        blk_data <= ~blk_data;
    endtask
    // one marker on all lanes; bip byte per lane parity
    task automatic send_marker(input logic go, input logic [7:0] ev,
                               input logic [7:0] od);
        @(posedge clock);
        if (!go) begin
            idle_lanes();
        end else begin
            for (int g = 0; g < LANES; g++)
                blk_data[g*66 +: 66] <= {32'h0, g[0] ? od : ev, 24'h0, 2'b01};
            blk_valid <= '1;
            blk_marker <= '1;
        end
    endtask
    task automatic bad_headers(input int n);
        repeat (n) begin
            @(posedge clock);
            blk_data <= '0;
            blk_valid <= '1;
            blk_marker <= '0;
        end
        @(posedge clock);
        idle_lanes();
    endtask
    task automatic send_cols(input int n, input logic lf, input logic sq);
        repeat (n) begin
            @(posedge clock);
            col_valid <= 1'b1;
            col_is_lf <= lf;
            col_is_seq <= sq;
        end
        @(posedge clock);
        col_valid <= 1'b0;
        col_is_lf <= ~col_is_lf;
        col_is_seq <= ~col_is_seq;
    endtask
endmodule

// File: sim/rles_top_sva.sv
`timescale 1ns/10ps
module rles_check #(
    parameter LANES          = 20,
    parameter BER_WINDOW_CYC = 15625
) (
    // clock and reset
    input wire                clock,
    input wire                reset,
    // register port
    input wire [7:0]          reg_addr,
    input wire [31:0]         reg_wdata,
    input wire                reg_wr,
    input wire                reg_rd,
    input wire [31:0]         reg_rdata,
    // receive inputs and transmit test mode
    input wire                pkt_valid,
    input wire                pkt_sop,
    input wire [6:0]          pkt_bytes,
    input wire [LANES-1:0]    blk_valid,
    input wire [LANES*66-1:0] blk_data,
    input wire [LANES-1:0]    blk_marker,
    input wire                lanes_aligned,
    input wire                col_valid,
    input wire                col_is_lf,
    input wire                col_is_seq,
    input wire                tx_test_pattern,
    // status outputs
    input wire                rx_truncated,
    input wire                rx_internal_local_fault,
    input wire                rx_received_local_fault,
    input wire [LANES-1:0]    rx_bip_err,
    input wire                rx_error_rate_high_flag,
    input wire                irq
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    a_trunc_cause: assert property (
        rx_truncated |-> $past(pkt_valid))
        else $error("truncation pulse without a packet beat");
    // the flag output is the internal rate register, so one stage behind
    a_ilf_follows: assert property (
        !$past(reset) |-> rx_internal_local_fault == $past(tx_test_pattern
        || !lanes_aligned || rx_error_rate_high_flag))
        else $error("internal fault does not follow its causes");
    a_test_fault: assert property (
        !$past(reset) && $past(tx_test_pattern) |-> rx_internal_local_fault)
        else $error("test pattern did not raise internal fault");
    a_rlf_rise: assert property (
        $rose(rx_received_local_fault) |-> $past(col_valid && col_is_lf))
        else $error("received fault rose without a fault column");
    a_bip_lane0: assert property (
        rx_bip_err[0] |-> $past(blk_valid[0] && blk_marker[0]))
        else $error("lane 0 error without a marker");
    a_bip_lanes: assert property (
        (rx_bip_err & ~$past(blk_valid & blk_marker)) == '0)
        else $error("lane error without a marker on that lane");
    a_hiber_rise: assert property (
        $rose(rx_error_rate_high_flag)
        |-> $past(lanes_aligned && (blk_valid != '0)))
        else $error("rate flag rose without counted blocks");
    a_reset_quiet: assert property (
        disable iff (1'b0) reset |=> !rx_truncated && !irq
        && !rx_internal_local_fault && !rx_received_local_fault
        && rx_bip_err == '0 && !rx_error_rate_high_flag)
        else $error("indicator high during reset");

    c_trunc_b2b: cover property (rx_truncated ##1 rx_truncated);
    c_bip_b2b: cover property (rx_bip_err[0] ##1 rx_bip_err[0]);
    c_rlf_rise: cover property ($rose(rx_received_local_fault));
    c_hiber_fall: cover property ($fell(rx_error_rate_high_flag));
endmodule

bind rles_top rles_check #(
    .LANES(LANES), .BER_WINDOW_CYC(BER_WINDOW_CYC)
) u_check (
    .clock(clock), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pkt_valid(pkt_valid), .pkt_sop(pkt_sop),
    .pkt_bytes(pkt_bytes), .blk_valid(blk_valid), .blk_data(blk_data),
    .blk_marker(blk_marker), .lanes_aligned(lanes_aligned),
    .col_valid(col_valid), .col_is_lf(col_is_lf),
    .col_is_seq(col_is_seq), .tx_test_pattern(tx_test_pattern),
    .rx_truncated(rx_truncated),
    .rx_internal_local_fault(rx_internal_local_fault),
    .rx_received_local_fault(rx_received_local_fault),
    .rx_bip_err(rx_bip_err),
    .rx_error_rate_high_flag(rx_error_rate_high_flag), .irq(irq)
);

// File: sim/tb_rles_top.sv
`timescale 1ns/10ps
`include "rles_map.vh"
module tb_rles_top;
    logic          clock = 1'b0;
    logic          reset = 1'b1;
    logic [7:0]    reg_addr = 8'h00;
    logic [31:0]   reg_wdata = 32'h0;
    logic          reg_wr = 1'b0;
    logic          reg_rd = 1'b0;
    logic          pkt_valid = 1'b0;
    logic          pkt_sop = 1'b0;
    logic [6:0]    pkt_bytes = 7'h00;
    logic          lanes_aligned = 1'b1;
    logic          tx_test_pattern = 1'b0;
    logic [31:0]   rdv;
    wire  [31:0]   reg_rdata;
    wire  [19:0]   blk_valid, blk_marker, bip_err;
    wire  [1319:0] blk_data;
    wire           col_valid, col_is_lf, col_is_seq;
    wire           trunc, ilf, rlf, hiber, irq;
    int            bad_count = 0;
    int            samples_checked = 0;
    int            cycles = 0;

    always #4 clock = ~clock;

    rles_top #(.LANES(20), .BER_WINDOW_CYC(200)) dut (
        .clock(clock), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .pkt_valid(pkt_valid), .pkt_sop(pkt_sop),
        .pkt_bytes(pkt_bytes), .blk_valid(blk_valid), .blk_data(blk_data),
        .blk_marker(blk_marker), .lanes_aligned(lanes_aligned),
        .col_valid(col_valid), .col_is_lf(col_is_lf),
        .col_is_seq(col_is_seq), .tx_test_pattern(tx_test_pattern),
        .rx_truncated(trunc), .rx_internal_local_fault(ilf),
        .rx_received_local_fault(rlf), .rx_bip_err(bip_err),
        .rx_error_rate_high_flag(hiber), .irq(irq));
    rles_link_model #(.LANES(20)) lm (
        .clock(clock), .blk_valid(blk_valid), .blk_data(blk_data),
        .blk_marker(blk_marker), .col_valid(col_valid),
        .col_is_lf(col_is_lf), .col_is_seq(col_is_seq));

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        samples_checked++;
        if (seen !== want) begin
            bad_count++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, want);
        end
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [7:0] a);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 rdv = reg_rdata;
    endtask
    task automatic close_out();
        $display("checks %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic test_regs();
        check({trunc, ilf, rlf, hiber, irq, bip_err}, 32'h0);
        reg_read(`RLES_REG_CTRL);
        check(rdv, 32'h2580);
        reg_read(`RLES_REG_INT_MASK);
        check(rdv, 32'h0);
        reg_read(`RLES_REG_INT_STAT);
        check(rdv, 32'h0);
        reg_read(8'h20);
        check(rdv, 32'h0);
        reg_write(`RLES_REG_CTRL, 32'hFFFFFFFF);
        reg_read(`RLES_REG_CTRL);
        check(rdv, 32'h7FFF);
        reg_write(`RLES_REG_LEVEL, 32'h1F);
        reg_read(`RLES_REG_LEVEL);
        check(rdv, 32'h0);
        $display("test_regs done");
    endtask
    // limit 63: equal length passes, one more byte cuts, back to back
    task automatic test_trunc();
        logic [4:0] sop = 5'b10101;
        logic [4:0] want = 5'b00110;
        logic [6:0] len [5] = '{7'h3F, 7'h01, 7'h40, 7'h40, 7'h3F};
        reg_write(`RLES_REG_CTRL, 32'h3F);
        for (int i = 0; i <= 5; i++) begin
            @(posedge clock);
            pkt_valid <= (i < 5);
            pkt_sop <= sop[i % 5];
            pkt_bytes <= len[i % 5];
            #1;
            if (i > 0) check(trunc, want[i-1]);
        end
        check(irq, 1'b0);
        reg_write(`RLES_REG_INT_MASK, 32'h1);
        repeat (2) @(posedge clock);
        #1 check(irq, 1'b1);
        reg_read(`RLES_REG_INT_STAT);
        check(rdv, 32'h1);
        check(irq, 1'b0);
        $display("test_trunc done");
    endtask
    task automatic test_ilf();
        logic [3:0] tx = 4'b0001;
        logic [3:0] al = 4'b1011;
        logic [3:0] want = 4'b0101;
        for (int i = 0; i < 4; i++) begin
            @(posedge clock);
            tx_test_pattern <= tx[i];
            lanes_aligned <= al[i];
            @(posedge clock);
            #1 check(ilf, want[i]);
        end
        $display("test_ilf done");
    endtask
    task automatic test_rlf();
        lm.send_cols(3, 1'b1, 1'b0);
        #1 check(rlf, 1'b0);
        lm.send_cols(1, 1'b1, 1'b0);
        #1 check(rlf, 1'b1);
        lm.send_cols(127, 1'b0, 1'b0);
        #1 check(rlf, 1'b1);
        lm.send_cols(1, 1'b0, 1'b0);
        @(posedge clock);
        #1 check(rlf, 1'b0);
        lm.send_cols(4, 1'b1, 1'b0);
        #1 check(rlf, 1'b1);
        lm.send_cols(1, 1'b0, 1'b1);
        @(posedge clock);
        #1 check(rlf, 1'b0);
        $display("test_rlf done");
    endtask
    // a bare marker's parity is its bip byte with bit 3 flipped by sync
    task automatic test_bip();
        logic [7:0] ev [6] = '{8'h00, 8'h08, 8'h08, 8'h00, 8'h55, 8'h00};
        logic [7:0] od [6] = '{8'h00, 8'h08, 8'h00, 8'h08, 8'h00, 8'h00};
        logic [5:0] e_err = 6'b110100;
        logic [5:0] o_err = 6'b100000;
        for (int i = 0; i <= 6; i++) begin
            lm.send_marker(i < 6, ev[i % 6], od[i % 6]);
            #1;
            if (i > 0)
                check(bip_err, {10{o_err[i-1], e_err[i-1]}});
        end
        reg_read(`RLES_REG_BIP_CNT);
        check(rdv, 32'h28);
        reg_read(`RLES_REG_BIP_CNT);
        check(rdv, 32'h0);
        $display("test_bip done");
    endtask
    task automatic test_ber();
        check(hiber, 1'b0);
        lm.bad_headers(10);
        #1 check(hiber, 1'b1);
        @(posedge clock);
        #1 check(ilf, 1'b1);
        for (int n = 0; n < 450 && hiber === 1'b1; n++) @(posedge clock);
        #1 check(hiber, 1'b0);
        repeat (2) @(posedge clock);
        #1 check(ilf, 1'b0);
        $display("test_ber done");
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            close_out();
        end
    end

    initial begin
        repeat (6) @(posedge clock);
        reset <= 1'b0;
        #1;
        test_regs();
        test_trunc();
        test_ilf();
        test_rlf();
        test_bip();
        test_ber();
        close_out();
    end
endmodule

// File: verilog/rles_lane_bip.v
`timescale 1ns/10ps
`include "rles_map.vh"

module rles_lane_bip (
    // clock and reset
    input  wire        clock,
    input  wire        reset,
    // one lane of 66-bit blocks
    input  wire        blk_valid,
    input  wire [65:0] blk_data,
    input  wire        blk_marker,
    // error pulse
    output wire        bip_err
);

    reg  [7:0] acc_ff;
    reg        seen_ff;
    reg        err_ff;
    wire [7:0] blk_par;

    // interleaved parity of one block; header bits fold into bits 3 and 4
    function [7:0] blk_bip;
        input [65:0] b;
        integer j;
        integer k;
        begin
            blk_bip = 8'h00;
            for (j = 0; j < 8; j = j + 1) begin
                for (k = 0; k < 8; k = k + 1) begin
                    blk_bip[j] = blk_bip[j] ^ b[2 + j + 8 * k];
                end
            end
            blk_bip[3] = blk_bip[3] ^ b[0];
            blk_bip[4] = blk_bip[4] ^ b[1];
        end
    endfunction

    assign blk_par = blk_bip(blk_data);
    assign bip_err = err_ff;

    always @(posedge clock) begin
        if (reset) begin
            acc_ff  <= 8'h00;
            seen_ff <= 1'b0;
            err_ff  <= 1'b0;                                  // [RULE_08]
        end else begin
            err_ff <= 1'b0;                                   // [RULE_04]
            if (blk_valid) begin
                if (blk_marker) begin
                    // first marker after reset has no full span behind it
                    err_ff  <= seen_ff && (acc_ff !=
                        blk_data[`RLES_MARK_BIP_MSB:`RLES_MARK_BIP_LSB]);
                    seen_ff <= 1'b1;                          // [RULE_04]
                    acc_ff  <= blk_par;
                end else begin
                    acc_ff  <= acc_ff ^ blk_par;
                end
            end
        end
    end

endmodule

// File: verilog/rles_map.vh
`ifndef RLES_MAP_VH
`define RLES_MAP_VH

// register byte offsets
`define RLES_REG_CTRL       8'h00
`define RLES_REG_LEVEL      8'h04
`define RLES_REG_INT_STAT   8'h08
`define RLES_REG_INT_MASK   8'h0C
`define RLES_REG_BIP_CNT    8'h10

// control register fields and reset value
`define RLES_CTRL_MAXLEN_MSB 14
`define RLES_MAXLEN_RST      15'h2580

// level register and interrupt bit positions
`define RLES_BIT_TRUNC      0
`define RLES_BIT_ILF        1
`define RLES_BIT_RLF        2
`define RLES_BIT_BIP        3
`define RLES_BIT_HIBER      4
`define RLES_INT_W          5
`define RLES_INT_MASK_RST   5'h00

// clock and timing
`define RLES_CLK_MHZ        125
`define RLES_BER_WINDOW_NS  125000
`define RLES_BER_LIMIT      97
`define RLES_LF_SEQ_LIMIT   4
`define RLES_LF_COL_LIMIT   128

// bip byte position inside a lane marker block
`define RLES_MARK_BIP_LSB   26
`define RLES_MARK_BIP_MSB   33

`endif

// File: verilog/rles_top.v
// Overview of operation
// RULE_01: pulse truncation one cycle when length exceeds the maximum.
// RULE_02: internal fault while test pattern, misaligned lanes or high rate.
// RULE_03: received fault set by partner fault words, held while they last.
// RULE_04: lane 0 error pulses one cycle per bad BIP8 byte, pulses may abut.
// RULE_05: lanes 1 to 19 each have their own identical error output.
// RULE_06: high error rate flag is a level, set while rate exceeds threshold.
// RULE_07: transmit test pattern enable counts as an internal fault cause.
// RULE_08: all indicators are held low during reset.
//
// Implementation choices: strobed register access and the register offsets.
`timescale 1ns/10ps
`include "rles_map.vh"

module rles_top #(
    parameter LANES          = 20,
    parameter BER_WINDOW_CYC =
        (`RLES_BER_WINDOW_NS * `RLES_CLK_MHZ) / 1000
) (
    // clock and reset
    input  wire                 clock,
    input  wire                 reset,
    // register port
    input  wire [7:0]           reg_addr,
    input  wire [31:0]          reg_wdata,
    input  wire                 reg_wr,
    input  wire                 reg_rd,
    output wire [31:0]          reg_rdata,
    // receive packet stream
    input  wire                 pkt_valid,
    input  wire                 pkt_sop,
    input  wire [6:0]           pkt_bytes,
    // pcs lanes
    input  wire [LANES-1:0]     blk_valid,
    input  wire [LANES*66-1:0]  blk_data,
    input  wire [LANES-1:0]     blk_marker,
    input  wire                 lanes_aligned,
    // column stream for fault detection
    input  wire                 col_valid,
    input  wire                 col_is_lf,
    input  wire                 col_is_seq,
    // transmit test mode
    input  wire                 tx_test_pattern,
    // status outputs
    output wire                 rx_truncated,
    output wire                 rx_internal_local_fault,
    output wire                 rx_received_local_fault,
    output wire [LANES-1:0]     rx_bip_err,
    output wire                 rx_error_rate_high_flag,
    output wire                 irq
);

    localparam ST_IDLE  = 2'd0;
    localparam ST_COUNT = 2'd1;
    localparam ST_FAULT = 2'd2;

    localparam [6:0]  BER_LIMIT = `RLES_BER_LIMIT;
    localparam [2:0]  SEQ_LIMIT = `RLES_LF_SEQ_LIMIT;
    localparam [31:0] COL_LAST_W = `RLES_LF_COL_LIMIT - 1;
    localparam [31:0] BER_LAST_W = BER_WINDOW_CYC - 1;
    localparam [7:0]  COL_LIMIT = COL_LAST_W[7:0];
    localparam [15:0] BER_LAST  = BER_LAST_W[15:0];

    reg  [14:0]            max_len_ff;
    reg  [`RLES_INT_W-1:0] int_stat_ff;
    reg  [`RLES_INT_W-1:0] int_mask_ff;
    reg  [15:0]            bip_cnt_ff;
    reg  [31:0]            rdata_ff;
    reg                    irq_ff;
    reg  [15:0]            len_ff;
    reg                    trunc_done_ff;
    reg                    trunc_ff;
    reg  [15:0]            win_ff;
    reg  [6:0]             bad_ff;
    reg                    hiber_ff;
    reg                    ilf_ff;
    reg  [1:0]             state_ff;
    reg  [2:0]             seq_ff;
    reg  [7:0]             col_ff;
    reg                    rlf_ff;

    reg  [15:0]            nxt_len;
    reg  [7:0]             nxt_bad;
    reg                    nxt_hiber;
    reg  [1:0]             nxt_state;
    reg  [2:0]             nxt_seq;
    reg  [7:0]             nxt_col;
    reg  [`RLES_INT_W-1:0] nxt_event;
    reg  [31:0]            nxt_rdata;
    reg  [16:0]            nxt_bip_cnt;

    wire [LANES-1:0]       hdr_bad;
    wire [LANES-1:0]       bip_pulse;
    wire                   nxt_trunc;
    wire                   nxt_ilf;
    wire                   nxt_rlf;
    wire                   rd_stat;
    wire                   rd_bip;
    wire [4:0]             bad_now;
    wire [4:0]             bip_now;

    // count of set bits in a lane vector
    function [4:0] pop_lanes;
        input [LANES-1:0] v;
        integer i;
        begin
            pop_lanes = 5'h00;
            for (i = 0; i < LANES; i = i + 1) begin
                pop_lanes = pop_lanes + {4'h0, v[i]};
            end
        end
    endfunction

    genvar g;
    generate
        for (g = 0; g < LANES; g = g + 1) begin : lane
            // a sync header of 00 or 11 is invalid
            assign hdr_bad[g] = blk_valid[g] &&
                (blk_data[g*66] == blk_data[g*66+1]);
            rles_lane_bip u_bip (
                .clock      (clock),
                .reset      (reset),
                .blk_valid  (blk_valid[g]),
                .blk_data   (blk_data[g*66 +: 66]),
                .blk_marker (blk_marker[g]),
                .bip_err    (bip_pulse[g])                    // [RULE_05]
            );
        end
    endgenerate

    assign bad_now = pop_lanes(hdr_bad);
    assign bip_now = pop_lanes(bip_pulse);

    // running packet length; one pulse per packet at the crossing
    always @* begin
        nxt_len = pkt_sop ? {9'h000, pkt_bytes}
                          : len_ff + {9'h000, pkt_bytes};
        if (!pkt_sop && len_ff > 16'hFF80) begin
            nxt_len = 16'hFFFF;
        end
    end

    assign nxt_trunc = pkt_valid && (pkt_sop || !trunc_done_ff) &&
                       (nxt_len > {1'b0, max_len_ff});        // [RULE_01]

    always @(posedge clock) begin
        if (reset) begin
            len_ff        <= 16'h0000;
            trunc_done_ff <= 1'b0;
            trunc_ff      <= 1'b0;                            // [RULE_08]
        end else begin
            trunc_ff <= nxt_trunc;                            // [RULE_01]
            if (pkt_valid) begin
                len_ff <= nxt_len;
                if (pkt_sop) begin
                    trunc_done_ff <= nxt_trunc;
                end else if (nxt_trunc) begin
                    trunc_done_ff <= 1'b1;
                end
            end
        end
    end

    // bad header count over a fixed window; set at once, cleared at window end
    always @* begin
        nxt_bad   = {1'b0, bad_ff} + {3'h0, bad_now};
        nxt_hiber = hiber_ff;
        if (nxt_bad > {1'b0, BER_LIMIT}) begin
            nxt_bad = {1'b0, BER_LIMIT};
        end
        if (nxt_bad[6:0] >= BER_LIMIT) begin
            nxt_hiber = 1'b1;                                 // [RULE_06]
        end else if (win_ff == BER_LAST) begin
            nxt_hiber = 1'b0;                                 // [RULE_06]
        end
    end

    always @(posedge clock) begin
        if (reset) begin
            win_ff   <= 16'h0000;
            bad_ff   <= 7'h00;
            hiber_ff <= 1'b0;                                 // [RULE_08]
        end else if (!lanes_aligned) begin
            // counting is meaningless until lanes line up
            win_ff   <= 16'h0000;
            bad_ff   <= 7'h00;
        end else begin
            hiber_ff <= nxt_hiber;
            if (win_ff == BER_LAST) begin
                win_ff <= 16'h0000;
                bad_ff <= 7'h00;
            end else begin
                win_ff <= win_ff + 16'h0001;
                bad_ff <= nxt_bad[6:0];
            end
        end
    end

    // uses the registered rate flag, so it trails it by one cycle
    assign nxt_ilf = tx_test_pattern ||                       // [RULE_07]
                     !lanes_aligned || hiber_ff;              // [RULE_02]

    // fault sequence counting over columns
    always @* begin
        nxt_state = state_ff;
        nxt_seq   = seq_ff;
        nxt_col   = col_ff;
        if (col_valid) begin
            case (state_ff)
                ST_IDLE: begin
                    if (col_is_lf) begin
                        nxt_state = ST_COUNT;
                        nxt_seq   = 3'd1;
                        nxt_col   = 8'h00;
                    end
                end
                ST_COUNT, ST_FAULT: begin
                    if (col_is_lf) begin
                        nxt_col = 8'h00;
                        if (state_ff == ST_COUNT) begin
                            nxt_seq = seq_ff + 3'd1;
                            if (nxt_seq >= SEQ_LIMIT) begin
                                nxt_state = ST_FAULT;         // [RULE_03]
                            end
                        end
                    end else if (col_is_seq) begin
                        nxt_state = ST_IDLE;
                    end else if (col_ff == COL_LIMIT) begin
                        nxt_state = ST_IDLE;                  // [RULE_03]
                    end else begin
                        nxt_col = col_ff + 8'h01;
                    end
                end
                default: begin
                    nxt_state = ST_IDLE;
                end
            endcase
        end
    end

    assign nxt_rlf = (nxt_state == ST_FAULT);                 // [RULE_03]

    always @(posedge clock) begin
        if (reset) begin
            state_ff <= ST_IDLE;
            seq_ff   <= 3'd0;
            col_ff   <= 8'h00;
            rlf_ff   <= 1'b0;                                 // [RULE_08]
            ilf_ff   <= 1'b0;                                 // [RULE_08]
        end else begin
            state_ff <= nxt_state;
            seq_ff   <= nxt_seq;
            col_ff   <= nxt_col;
            rlf_ff   <= nxt_rlf;
            ilf_ff   <= nxt_ilf;                              // [RULE_02]
        end
    end

    // interrupt events: pulses and rising edges of the levels
    always @* begin
        nxt_event = {`RLES_INT_W{1'b0}};
        nxt_event[`RLES_BIT_TRUNC] = nxt_trunc;
        nxt_event[`RLES_BIT_ILF]   = nxt_ilf && !ilf_ff;
        nxt_event[`RLES_BIT_RLF]   = nxt_rlf && !rlf_ff;
        nxt_event[`RLES_BIT_BIP]   = |bip_pulse;
        nxt_event[`RLES_BIT_HIBER] = nxt_hiber && !hiber_ff && lanes_aligned;
    end

    assign rd_stat = reg_rd && (reg_addr == `RLES_REG_INT_STAT);
    assign rd_bip  = reg_rd && (reg_addr == `RLES_REG_BIP_CNT);

    always @* begin
        nxt_bip_cnt = {1'b0, rd_bip ? 16'h0000 : bip_cnt_ff} +
                      {12'h000, bip_now};
        if (nxt_bip_cnt[16]) begin
            nxt_bip_cnt = 17'h0FFFF;
        end
    end

    always @* begin
        nxt_rdata = 32'h0000_0000;
        case (reg_addr)
            `RLES_REG_CTRL: begin
                nxt_rdata[`RLES_CTRL_MAXLEN_MSB:0] = max_len_ff;
            end
            `RLES_REG_LEVEL: begin
                nxt_rdata[`RLES_BIT_TRUNC] = trunc_ff;
                nxt_rdata[`RLES_BIT_ILF]   = ilf_ff;
                nxt_rdata[`RLES_BIT_RLF]   = rlf_ff;
                nxt_rdata[`RLES_BIT_BIP]   = |bip_pulse;
                nxt_rdata[`RLES_BIT_HIBER] = hiber_ff;
            end
            `RLES_REG_INT_STAT: begin
                nxt_rdata[`RLES_INT_W-1:0] = int_stat_ff;
            end
            `RLES_REG_INT_MASK: begin
                nxt_rdata[`RLES_INT_W-1:0] = int_mask_ff;
            end
            `RLES_REG_BIP_CNT: begin
                nxt_rdata[15:0] = bip_cnt_ff;
            end
            default: begin
                nxt_rdata = 32'h0000_0000;
            end
        endcase
    end

    always @(posedge clock) begin
        if (reset) begin
            max_len_ff  <= `RLES_MAXLEN_RST;
            int_mask_ff <= `RLES_INT_MASK_RST;
            int_stat_ff <= {`RLES_INT_W{1'b0}};
            bip_cnt_ff  <= 16'h0000;
            rdata_ff    <= 32'h0000_0000;
            irq_ff      <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == `RLES_REG_CTRL) begin
                max_len_ff <= reg_wdata[`RLES_CTRL_MAXLEN_MSB:0];
            end
            if (reg_wr && reg_addr == `RLES_REG_INT_MASK) begin
                int_mask_ff <= reg_wdata[`RLES_INT_W-1:0];
            end
            // a new event in the clearing read cycle survives the clear
            int_stat_ff <= (rd_stat ? {`RLES_INT_W{1'b0}} : int_stat_ff) |
                           nxt_event;
            bip_cnt_ff  <= nxt_bip_cnt[15:0];
            rdata_ff    <= reg_rd ? nxt_rdata : 32'h0000_0000;
            irq_ff      <= |(((rd_stat ? {`RLES_INT_W{1'b0}} : int_stat_ff) |
                             nxt_event) & int_mask_ff);
        end
    end

    assign reg_rdata               = rdata_ff;
    assign irq                     = irq_ff;
    assign rx_truncated            = trunc_ff;
    assign rx_internal_local_fault = ilf_ff;
    assign rx_received_local_fault = rlf_ff;
    assign rx_bip_err              = bip_pulse;               // [RULE_04]
    assign rx_error_rate_high_flag = hiber_ff;                // [RULE_06]

endmodule
